// *** rtl/base_interval_timer_defines.svh ***
// constants for the base interval timer: offsets, fields, reset values, masks
// Summary of operation
// - an 8-bit stage carries into a 6-bit stage, forming a 14-bit up-counter.
// - period select 1 sets interrupt 0 flag on each 6-bit overflow, 64 clocks.
// - period select 0 sets interrupt 0 flag on each 14-bit overflow, 16384 clocks.
// - 6-bit stage counts input clock directly or 8-bit overflow; fast mode needs 1.
// - run bit 0 stops the timer at count zero; run bit 1 counts continuously.
// - with select 0, interrupt 1 period is 32, 128, 512 or 2048 clocks.
// - with select 1, interrupt 1 period is 32, 128, 2 or 8 clocks.
// - interrupt 1 flag sets each period and stays until software clears it.
// - interrupt 0 flag sets each period and stays until software clears it.
// - interrupt 1 enable and flag both set raise request and hold release.
// - interrupt 0 enable and flag both set raise request and hold release.
// - rewriting interrupt 1 period bits while counting may set its flag.
// - timer keeps counting in crystal hold when power control bit 2 set.
// - buzzer waveform comes from the 8-bit stage, routable to the port pin.
// - software can clear both counter stages.
// - source field 00 subclock, 01 cycle clock, 10 subclock, 11 timer 0 prescaler.
// - buzzer select 1 forces pwm high and sends clock/16; 0 holds buzzer high.
`ifndef BASE_INTERVAL_TIMER_DEFINES_SVH
`define BASE_INTERVAL_TIMER_DEFINES_SVH

`define INPUT_SIGNAL_SELECT_IDX 18'h0FE5F
`define BASE_TIMER_CONTROL_IDX 18'h0FE7F
`define COUNT_CLEAR_IDX 18'h0FE80

`define INPUT_SIGNAL_SELECT_RST 8'h00
`define BASE_TIMER_CONTROL_RST 8'h00

`define IRQ0_PERIOD_SELECT_BIT 7
`define RUN_CONTROL_BIT 6
`define IRQ1_PERIOD_HI_BIT 5
`define IRQ1_PERIOD_LO_BIT 4
`define IRQ1_FLAG_BIT 3
`define IRQ1_ENABLE_BIT 2
`define IRQ0_FLAG_BIT 1
`define IRQ0_ENABLE_BIT 0
`define CLOCK_SOURCE_HI_BIT 5
`define CLOCK_SOURCE_LO_BIT 4
`define BUZZER_SELECT_BIT 3
`define COUNT_CLEAR_BIT 0
`define BUZZER_TAP_BIT 3

`define IRQ1_MASK_32 14'h001F
`define IRQ1_MASK_128 14'h007F
`define IRQ1_MASK_512 14'h01FF
`define IRQ1_MASK_2048 14'h07FF
`define IRQ1_MASK_2 14'h0001
`define IRQ1_MASK_8 14'h0007
`define COUNT14_FULL 14'h3FFF
`define COUNT8_FULL 8'hFF
`define COUNT6_FULL 6'h3F

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** rtl/base_interval_timer_pkg.sv ***
// types shared by the base interval timer files
package base_interval_timer_pkg;

  typedef enum logic [1:0]
  {
    SRC_SUBCLOCK = 2'b00,
    SRC_CYCLE = 2'b01,
    SRC_SUBCLOCK_ALT = 2'b10,
    SRC_T0_PRESCALE = 2'b11
  } clock_source_e;

  typedef struct packed
  {
    logic [19:0] addr;
    logic [2:0] prot;
  } axil_addr_s;

  typedef struct packed
  {
    logic [31:0] data;
    logic [3:0] strb;
  } axil_wdata_s;

  typedef struct packed
  {
    logic [31:0] data;
    logic [1:0] resp;
  } axil_rdata_s;

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_s;

  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [7:0] isel;
    logic [7:0] cnt8;
    logic [5:0] cnt6;
    logic aw_got;
    logic [19:0] awaddr;
    logic w_got;
    axil_wdata_s wbuf;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    axil_rdata_s rd;
    logic irq;
    logic hold_release;
    logic buzzer;
    logic pwmh;
  } bt_state_s;

endpackage

// *** rtl/edge_sync3.sv ***
// three-flop synchroniser with rising-edge pulse for an asynchronous count clock
`timescale 1ns/1ps
module edge_sync3
  import base_interval_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_rise
);

  sync_state_s st_ff;
  sync_state_s nxt_st;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = i_async;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3)
    begin
      nxt_st.lvl = st_ff.s3;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_rise = (st_ff.s2 == st_ff.s3) && st_ff.s3 && !st_ff.lvl;

endmodule

// *** rtl/base_interval_timer.sv ***
// base interval timer: 14-bit counter, two interrupt flags, buzzer, axi4-lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "base_interval_timer_defines.svh"
module base_interval_timer
  import base_interval_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire axil_addr_s i_aw,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire axil_wdata_s i_w,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire axil_addr_s i_ar,
  output logic o_rvalid,
  input wire logic i_rready,
  output axil_rdata_s o_r,
  input wire logic i_subclock,
  input wire logic i_cycle_tick,
  input wire logic i_t0_prescale_tick,
  input wire logic i_xtal_hold,
  input wire logic i_power_control_bt_en,
  input wire logic i_pwmh,
  output logic o_irq,
  output logic o_hold_release,
  output logic o_buzzer,
  output logic o_pwmh
);

  bt_state_s st_ff;
  bt_state_s nxt_st;
  logic sub_rise;
  logic tick;
  logic adv;
  logic fst;
  logic [13:0] cnt14;
  logic [13:0] mask1;
  logic irq0_hit;
  logic irq1_hit;
  logic do_wr;
  logic wr_ctrl;
  logic wr_isel;
  logic wr_clear;
  logic ar_hit_ok;

  function automatic logic reg_hit(input logic [19:0] addr, input logic [17:0] idx);
    reg_hit = (addr[19:2] == idx);
  endfunction

  function automatic logic mapped(input logic [19:0] addr);
    mapped = reg_hit(addr, `INPUT_SIGNAL_SELECT_IDX) || reg_hit(addr, `BASE_TIMER_CONTROL_IDX)
      || reg_hit(addr, `COUNT_CLEAR_IDX);
  endfunction

  function automatic logic [13:0] irq1_mask(input logic f, input logic [1:0] sel);
    case ({f, sel})
      3'b000: irq1_mask = `IRQ1_MASK_32;
      3'b001: irq1_mask = `IRQ1_MASK_128;
      3'b010: irq1_mask = `IRQ1_MASK_512;
      3'b011: irq1_mask = `IRQ1_MASK_2048;
      3'b100: irq1_mask = `IRQ1_MASK_32;
      3'b101: irq1_mask = `IRQ1_MASK_128;
      3'b110: irq1_mask = `IRQ1_MASK_2;
      default: irq1_mask = `IRQ1_MASK_8;
    endcase
  endfunction

  edge_sync3 u_sub_sync
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_subclock),
    .o_rise(sub_rise)
  );

  always_comb
  begin
    nxt_st = st_ff;
    fst = st_ff.ctrl[`IRQ0_PERIOD_SELECT_BIT];
    cnt14 = {st_ff.cnt6, st_ff.cnt8};
    // both subclock codes pick the pin; source changes while running may miscount
    case (clock_source_e'(st_ff.isel[`CLOCK_SOURCE_HI_BIT:`CLOCK_SOURCE_LO_BIT]))
      SRC_CYCLE: tick = i_cycle_tick;
      SRC_T0_PRESCALE: tick = i_t0_prescale_tick;
      default: tick = sub_rise;
    endcase
    // in crystal hold the timer only runs when power control allows it
    adv = tick && !(i_xtal_hold && !i_power_control_bt_en)
      && (st_ff.ctrl[`RUN_CONTROL_BIT] || cnt14 != 14'h0000);
    irq0_hit = adv && (fst ? (st_ff.cnt6 == `COUNT6_FULL) : (cnt14 == `COUNT14_FULL));
    mask1 = irq1_mask(fst, st_ff.ctrl[`IRQ1_PERIOD_HI_BIT:`IRQ1_PERIOD_LO_BIT]);
    // fast mode taps the 8-bit stage alone; period bits are sampled live, so a rewrite
    // while counting can land on a matching count and set the flag early
    irq1_hit = adv && (((fst ? {6'h00, st_ff.cnt8} : cnt14) & mask1) == mask1);

    do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    wr_ctrl = do_wr && st_ff.wbuf.strb[0] && reg_hit(st_ff.awaddr, `BASE_TIMER_CONTROL_IDX);
    wr_isel = do_wr && st_ff.wbuf.strb[0] && reg_hit(st_ff.awaddr, `INPUT_SIGNAL_SELECT_IDX);
    wr_clear = do_wr && st_ff.wbuf.strb[0] && reg_hit(st_ff.awaddr, `COUNT_CLEAR_IDX)
      && st_ff.wbuf.data[`COUNT_CLEAR_BIT];
    ar_hit_ok = mapped(i_ar.addr);

    if (i_awvalid && st_ff.awready)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = i_aw.addr;
      nxt_st.awready = 1'b0;
    end
    if (i_wvalid && st_ff.wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wbuf = i_w;
      nxt_st.wready = 1'b0;
    end
    if (do_wr)
    begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = mapped(st_ff.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st_ff.bvalid && i_bready)
    begin
      nxt_st.bvalid = 1'b0;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end
    if (wr_ctrl)
    begin
      nxt_st.ctrl = st_ff.wbuf.data[7:0];
    end
    if (wr_isel)
    begin
      nxt_st.isel = st_ff.wbuf.data[7:0];
    end

    // a set in the same cycle as a clearing write wins
    nxt_st.ctrl[`IRQ0_FLAG_BIT] = nxt_st.ctrl[`IRQ0_FLAG_BIT] | irq0_hit;
    nxt_st.ctrl[`IRQ1_FLAG_BIT] = nxt_st.ctrl[`IRQ1_FLAG_BIT] | irq1_hit;

    if (wr_clear)
    begin
      nxt_st.cnt8 = 8'h00;
      nxt_st.cnt6 = 6'h00;
    end
    else if (adv)
    begin
      nxt_st.cnt8 = st_ff.cnt8 + 8'h01;
      if (fst || st_ff.cnt8 == `COUNT8_FULL)
      begin
        nxt_st.cnt6 = st_ff.cnt6 + 6'h01;
      end
    end

    if (i_arvalid && st_ff.arready)
    begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rd.resp = ar_hit_ok ? `RESP_OKAY : `RESP_SLVERR;
      nxt_st.rd.data = 32'h0000_0000;
      if (reg_hit(i_ar.addr, `BASE_TIMER_CONTROL_IDX))
      begin
        nxt_st.rd.data = {24'h000000, st_ff.ctrl};
      end
      else if (reg_hit(i_ar.addr, `INPUT_SIGNAL_SELECT_IDX))
      begin
        nxt_st.rd.data = {24'h000000, st_ff.isel};
      end
      else if (reg_hit(i_ar.addr, `COUNT_CLEAR_IDX))
      begin
        nxt_st.rd.data = {18'h00000, cnt14};
      end
    end
    if (st_ff.rvalid && i_rready)
    begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // one shared request line; it also wakes the core from crystal hold
    nxt_st.irq = (nxt_st.ctrl[`IRQ1_ENABLE_BIT] && nxt_st.ctrl[`IRQ1_FLAG_BIT])
      || (nxt_st.ctrl[`IRQ0_ENABLE_BIT] && nxt_st.ctrl[`IRQ0_FLAG_BIT]);
    nxt_st.hold_release = nxt_st.irq;
    // clock/16 is bit 3 of the 8-bit stage
    nxt_st.buzzer = nxt_st.isel[`BUZZER_SELECT_BIT] ? nxt_st.cnt8[`BUZZER_TAP_BIT] : 1'b1;
    nxt_st.pwmh = nxt_st.isel[`BUZZER_SELECT_BIT] ? 1'b1 : i_pwmh;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.ctrl <= `BASE_TIMER_CONTROL_RST;
      st_ff.isel <= `INPUT_SIGNAL_SELECT_RST;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.buzzer <= 1'b1;
      st_ff.pwmh <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_awready = st_ff.awready;
  assign o_wready = st_ff.wready;
  assign o_bvalid = st_ff.bvalid;
  assign o_bresp = st_ff.bresp;
  assign o_arready = st_ff.arready;
  assign o_rvalid = st_ff.rvalid;
  assign o_r = st_ff.rd;
  assign o_irq = st_ff.irq;
  assign o_hold_release = st_ff.hold_release;
  assign o_buzzer = st_ff.buzzer;
  assign o_pwmh = st_ff.pwmh;

  property p_carry;
    @(posedge i_clk) disable iff (!i_rst_n)
    (adv && !wr_clear && !fst && st_ff.cnt8 == `COUNT8_FULL)
      |=> (st_ff.cnt8 == 8'h00 && st_ff.cnt6 == $past(st_ff.cnt6) + 6'h01);
  endproperty
  a_carry: assert property (p_carry) else $error("carry into 6-bit stage lost");

  property p_irq0_fast;
    @(posedge i_clk) disable iff (!i_rst_n)
    (adv && fst && st_ff.cnt6 == `COUNT6_FULL) |=> st_ff.ctrl[`IRQ0_FLAG_BIT];
  endproperty
  a_irq0_fast: assert property (p_irq0_fast) else $error("fast irq0 flag missed");

  property p_irq0_slow;
    @(posedge i_clk) disable iff (!i_rst_n)
    (adv && !fst && cnt14 == `COUNT14_FULL) |=> st_ff.ctrl[`IRQ0_FLAG_BIT] ##1 o_irq
      || !st_ff.ctrl[`IRQ0_ENABLE_BIT] || !st_ff.ctrl[`IRQ0_FLAG_BIT];
  endproperty
  a_irq0_slow: assert property (p_irq0_slow) else $error("14-bit irq0 flag missed");

  property p_stop_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!st_ff.ctrl[`RUN_CONTROL_BIT] && cnt14 == 14'h0000 && !wr_clear) |=> $stable(cnt14);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("timer ran past zero");

  property p_irq1_slow512;
    @(posedge i_clk) disable iff (!i_rst_n)
    (adv && !fst && st_ff.ctrl[`IRQ1_PERIOD_HI_BIT:`IRQ1_PERIOD_LO_BIT] == 2'b10
      && st_ff.cnt8 == `COUNT8_FULL && st_ff.cnt6[0]) |=> st_ff.ctrl[`IRQ1_FLAG_BIT];
  endproperty
  a_irq1_slow512: assert property (p_irq1_slow512) else $error("irq1 512 missed");

  property p_irq1_fast2;
    @(posedge i_clk) disable iff (!i_rst_n)
    (adv && fst && st_ff.ctrl[`IRQ1_PERIOD_HI_BIT:`IRQ1_PERIOD_LO_BIT] == 2'b10
      && st_ff.cnt8[0]) |=> st_ff.ctrl[`IRQ1_FLAG_BIT];
  endproperty
  a_irq1_fast2: assert property (p_irq1_fast2) else $error("irq1 period 2 missed");

  property p_flag_sticky;
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_ff.ctrl[`IRQ1_FLAG_BIT] && !wr_ctrl) |=> st_ff.ctrl[`IRQ1_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("irq1 flag dropped");

  property p_set_wins;
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_ctrl && irq0_hit) |=> st_ff.ctrl[`IRQ0_FLAG_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

  property p_irq_out;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_irq == ((st_ff.ctrl[`IRQ1_ENABLE_BIT] && st_ff.ctrl[`IRQ1_FLAG_BIT])
      || (st_ff.ctrl[`IRQ0_ENABLE_BIT] && st_ff.ctrl[`IRQ0_FLAG_BIT])) && o_irq == o_hold_release;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("request not flag and enable");

  property p_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_clear |=> cnt14 == 14'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("counter clear failed");

  property p_buzzer;
    @(posedge i_clk) disable iff (!i_rst_n)
    st_ff.isel[`BUZZER_SELECT_BIT] |-> o_pwmh && o_buzzer == st_ff.cnt8[`BUZZER_TAP_BIT];
  endproperty
  a_buzzer: assert property (p_buzzer) else $error("buzzer routing wrong");

  c_irq0: cover property (@(posedge i_clk) disable iff (!i_rst_n) irq0_hit);
  c_irq1_fast: cover property (@(posedge i_clk) disable iff (!i_rst_n) irq1_hit && fst);
  c_set_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_ctrl && irq1_hit);

endmodule

// *** tb/base_interval_timer_test.sv ***
// self-checking bench for the base interval timer
`timescale 1ns/1ps
`include "base_interval_timer_defines.svh"
module base_interval_timer_test
  import base_interval_timer_pkg::*;
;
  localparam logic [19:0] A_ISEL = {`INPUT_SIGNAL_SELECT_IDX, 2'b00};
  localparam logic [19:0] A_CTRL = {`BASE_TIMER_CONTROL_IDX, 2'b00};
  localparam logic [19:0] A_CNT = {`COUNT_CLEAR_IDX, 2'b00};
  localparam int P1[8] = '{32, 128, 512, 2048, 32, 128, 2, 8};
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  axil_addr_s aw = '0, ar = '0;
  axil_wdata_s w = '0;
  logic sub = 1'h0, cyc = 1'h0, t0 = 1'h0, hold = 1'h0, pen = 1'h0, pwm = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, hrel, buz, pwmo;
  logic [1:0] bresp;
  axil_rdata_s r;
  int n_mismatch = 0, n_tests = 0, t = 0, tc = 0, c8 = 0, c6 = 0, src = 0;
  logic run = 1'h0, fast = 1'h0, bz = 1'h0;
  logic [7:0] ctl = 8'h00;
  logic [31:0] d;
  logic [1:0] rs;

  always #20 i_clk = ~i_clk;

  // the tick loops wait on the model, so a cap on the whole run keeps a stall from hanging
  initial
  begin
    repeat (95000) @(posedge i_clk);
    n_mismatch++;
    $display("wrong value at %0t: run watchdog expired", $time);
    end_sim;
  end

  base_interval_timer u_base_interval_timer
  (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_awvalid(awvalid), .o_awready(awready), .i_aw(aw),
    .i_wvalid(wvalid), .o_wready(wready), .i_w(w),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_ar(ar),
    .o_rvalid(rvalid), .i_rready(rready), .o_r(r),
    .i_subclock(sub), .i_cycle_tick(cyc), .i_t0_prescale_tick(t0),
    .i_xtal_hold(hold), .i_power_control_bt_en(pen), .i_pwmh(pwm),
    .o_irq(irq), .o_hold_release(hrel), .o_buzzer(buz), .o_pwmh(pwmo)
  );

  task automatic end_sim;
    $display("mismatches %0d of %0d tests", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic to;
    n_mismatch++;
    $display("wrong value at %0t: bus wait ran out", $time);
    end_sim;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge i_clk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw <= '{addr: a, prot: 3'h0};
    w <= '{data: {24'h0, v}, strb: 4'hF};
    do
    begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (++k > 40) to;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [19:0] a);
    int k;
    k = 0;
    @(posedge i_clk);
    arvalid <= 1'h1;
    rready <= 1'h1;
    ar <= '{addr: a, prot: 3'h0};
    do
    begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'h0;
      if (++k > 40) to;
    end
    while (!rvalid);
    d = r.data;
    rs = r.resp;
    rready <= 1'h0;
  endtask

  // one count pulse on input s (0 subclock, 1 cycle, 3 prescaler); model follows
  task automatic tick(input int s);
    logic h;
    logic e;
    // no hold while the subclock drives the count: its restart could miscount
    h = ($urandom % 4) == 0 && src % 2 == 1;
    e = $urandom % 2;
    @(posedge i_clk);
    hold <= h;
    pen <= e;
    pwm <= $urandom % 2;
    if (s == 0) sub <= 1'h1;
    if (s == 1) cyc <= 1'h1;
    if (s == 3) t0 <= 1'h1;
    @(posedge i_clk);
    cyc <= 1'h0;
    t0 <= 1'h0;
    // subclock passes a synchroniser, so it stays high until counted
    if (s == 0) repeat (6) @(posedge i_clk);
    sub <= 1'h0;
    // the low phase must outlast the synchroniser as well, or the next rise is lost
    if (s == 0) repeat (6) @(posedge i_clk);
    if (((src % 2 == 0) ? 0 : src) == s && (run || c8 != 0 || c6 != 0) && !(h && !e))
    begin
      c8 = (c8 + 1) % 256;
      if (fast || c8 == 0) c6 = (c6 + 1) % 64;
      t++;
    end
  endtask

  // set edge may be at count all-ones or one later, so only certain cases are judged
  function automatic int ex(input int p);
    int a;
    int b;
    a = t / p - tc / p;
    b = (t + 1) / p - (tc + 1) / p;
    if (a > 0 && b > 0) return 1;
    if (a == 0 && b == 0) return 0;
    return 2;
  endfunction

  task automatic setc(input logic [7:0] v);
    wr(A_CTRL, v);
    chk(rs, `RESP_OKAY);
    ctl = v;
    run = v[6];
    fast = v[7];
    tc = t;
  endtask

  task automatic clr;
    wr(A_CNT, 8'h01);
    c8 = 0;
    c6 = 0;
    t = 0;
  endtask

  task automatic cka;
    int f1;
    int f0;
    rd(A_CNT);
    chk(d, c6 * 256 + c8);
    rd(A_CTRL);
    f1 = ex(P1[{ctl[7], ctl[5:4]}]);
    f0 = ex(fast ? 64 : 16384);
    chk(d & 32'hF5, ctl & 8'hF5);
    if (f1 < 2) chk(d[3], f1[0]);
    if (f0 < 2) chk(d[1], f0[0]);
    if (f1 < 2 && f0 < 2) chk({irq, hrel}, {2{ctl[2] & f1[0] | ctl[0] & f0[0]}});
    chk({buz, pwmo}, bz ? {c8[3], 1'h1} : {1'h1, pwm});
  endtask

  initial
  begin
    void'($urandom(32'hA150D929));
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'h1;
    rd(A_ISEL);
    chk(d, `INPUT_SIGNAL_SELECT_RST);
    rd(A_CTRL);
    chk(d, `BASE_TIMER_CONTROL_RST);
    rd(20'h00010);
    chk(d, 32'h0);
    chk(rs, `RESP_SLVERR);
    wr(20'h00010, 8'hFF);
    chk(rs, `RESP_SLVERR);
    wr(A_ISEL, 8'h10);
    src = 1;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
      begin
        wr(A_ISEL, 8'h18);
        bz = 1'h1;
      end
      clr;
      setc({i[2], 1'h1, i[1:0], 1'h0, i[0], 1'h0, ~i[0]});
      // each tick spans two cycles, so even the two-tick period keeps the cycle margin
      while (t < P1[i] + 1) tick(1);
      cka;
      setc(ctl);
      while (t < 2 * P1[i] - 2) tick(1);
      cka;
      while (t < 2 * P1[i] + 1) tick(1);
      cka;
    end
    clr;
    setc(8'hC0);
    while (t < 5) tick(1);
    setc(8'h80);
    repeat (300) tick(1);
    cka;
    clr;
    setc(8'h41);
    while (t < 16385) tick(1);
    cka;
    bz = 1'h0;
    for (int s = 0; s < 4; s++)
    begin
      setc(8'h00);
      clr;
      wr(A_ISEL, 8'(s * 16));
      src = s;
      setc(8'h40);
      for (int j = 0; j < 4; j++)
        if (j != 2) repeat (3) tick(j);
      cka;
    end
    end_sim;
  end
endmodule
